// ---- verilog/dfrm_depth_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - 204B depth counts in four-octet steps
// - 204B depth limited to K times F over four
// - 204C depth counts in eight-octet steps
// - 204C depth limited to E times 32
// - 512-octet buffer, 204C depth saturates at 64, 204B depth at 128
// - Depth from pointers, carries fixed offset
// - Separate input FIFO and core depths
// - SYSREF gate enable, state readable
// - Offset accepted from zero to K*S-1, also capped at the multiframe length in words less one
module dfrm_depth_monitor (
    input  wire logic                                   ref_clk_i,      // 200 MHz core clock
    input  wire logic                                   rst_n_i,        // Async, active low
    input  wire logic                                   link_valid_i,   // Word from link
    input  wire logic [dfrm_depth_pkg::DATA_W-1:0]      link_data_i,    // Four octets
    output logic                                        link_ready_o,   // Input FIFO has room
    input  wire logic                                   link_en_i,      // Link up request
    input  wire logic                                   mode_c_i,       // 1 = 204C, 0 = 204B
    input  wire logic [dfrm_depth_pkg::K_W-1:0]         frames_k_i,     // K
    input  wire logic [dfrm_depth_pkg::F_W-1:0]         octets_f_i,     // F
    input  wire logic [dfrm_depth_pkg::S_W-1:0]         samples_s_i,    // S
    input  wire logic [dfrm_depth_pkg::E_W-1:0]         mblk_e_i,       // E
    input  wire logic [dfrm_depth_pkg::OFS_W-1:0]       offset_i,       // Multiframe offset
    input  wire logic                                   sysref_i,       // External SYSREF
    input  wire logic                                   sysref_en_i,    // SYSREF gate enable
    output logic                                        sysref_en_o,    // Gate state readback
    input  wire logic                                   depth_req_i,    // Snapshot request
    output logic [1:0]                                  fifo_depth_o,   // Input FIFO depth
    output logic [dfrm_depth_pkg::DEPTH_W-1:0]          core_depth_o,   // Elastic depth
    output logic                                        depth_valid_o,  // Snapshot taken
    output logic                                        aligned_o,      // Buffer released
    output logic                                        out_valid_o,    // Word to receiver
    output logic [dfrm_depth_pkg::DATA_W-1:0]           out_data_o,     // Released word
    input  wire logic                                   out_ready_i     // Receiver accepts
);
    import dfrm_depth_pkg::*;

    // All core state in one record
    typedef struct packed {
        link_state_t                       st;          // Alignment state
        logic [EB_WORDS-1:0][DATA_W-1:0]   mem;         // Elastic storage, 512 octets
        logic [PTR_W-1:0]                  wr_ptr;      // Write pointer with wrap bit
        logic [PTR_W-1:0]                  rd_ptr;      // Read pointer with wrap bit
        logic [LMFC_W-1:0]                 lmfc;        // Multiframe word counter
        logic [LMFC_W-1:0]                 period;      // Multiframe length in words
        logic [LMFC_W-1:0]                 rel_pt;      // Release point in the multiframe
        logic [DEPTH_W-1:0]                max_units;   // Depth ceiling for current mode
        logic                              mode_c;      // Mode latched at link-up
        logic                              sysref_en;   // Registered gate enable
        logic                              sysref_prev; // SYSREF one cycle ago
        logic                              out_valid;   // Output word held
        logic [DATA_W-1:0]                 out_data;    // Output word
        logic [1:0]                        fifo_depth;  // Snapshot of input FIFO depth
        logic [DEPTH_W-1:0]                core_depth;  // Snapshot of elastic depth
        logic                              depth_valid; // Snapshot strobe
    } core_state_t;

    core_state_t s_reg;         // Registered state
    core_state_t s_next;        // Next state

    word_stream_if fifo_in ();  // Link to input FIFO
    word_stream_if fifo_out (); // Input FIFO to elastic buffer

    logic [1:0]         fifo_cnt;       // Live input FIFO occupancy
    logic               sysref_edge;    // Gated SYSREF rising edge
    logic               eb_full;        // No room in elastic storage
    logic               eb_empty;       // Nothing to release
    logic               wr_en;          // Word written this cycle
    logic               rd_en;          // Word released this cycle
    logic [PTR_W-1:0]   occ_words;      // Pointer difference
    logic [DEPTH_W-1:0] raw_units;      // Difference in mode units
    logic [DEPTH_W-1:0] depth_units;    // Difference after ceiling
    logic [LMFC_W-1:0]  cfg_period;     // Period from live configuration
    logic [LMFC_W-1:0]  cfg_ofs_max;    // Largest legal offset
    logic [LMFC_W-1:0]  cfg_max;        // Depth ceiling from live configuration

    // Input FIFO sits between the link and the elastic storage
    assign fifo_in.valid = link_valid_i;
    assign fifo_in.data  = link_data_i;
    assign link_ready_o  = fifo_in.ready;

    two_entry_buffer u_in_fifo (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .in_s      (fifo_in.snk),
        .out_s     (fifo_out.src),
        .count_o   (fifo_cnt)
    );

    // Outputs straight from the state record
    assign sysref_en_o   = s_reg.sysref_en;
    assign fifo_depth_o  = s_reg.fifo_depth;
    assign core_depth_o  = s_reg.core_depth;
    assign depth_valid_o = s_reg.depth_valid;
    assign aligned_o     = s_reg.st[2];
    assign out_valid_o   = s_reg.out_valid;
    assign out_data_o    = s_reg.out_data;

    // SYSREF only reaches the counter while the gate is open
    assign sysref_edge = sysref_i & ~s_reg.sysref_prev & s_reg.sysref_en;

    // Pointer arithmetic; the wrap bit tells full from empty
    assign occ_words = s_reg.wr_ptr - s_reg.rd_ptr;
    assign eb_full   = (occ_words == EB_FULL);
    assign eb_empty  = (occ_words == PTR_RST);

    // Writes continue while the link is up; a full buffer stalls the input FIFO,
    // which in turn drops link_ready_o, so no word is lost
    assign fifo_out.ready = ~s_reg.st[0] & ~eb_full;
    assign wr_en          = fifo_out.valid & fifo_out.ready;

    // Release only once aligned and only when the output slot frees up
    assign rd_en = s_reg.st[2] & ~eb_empty & (~s_reg.out_valid | out_ready_i);

    // Convert the pointer difference into reporting units
    always_comb begin
        if (s_reg.mode_c) begin
            raw_units = occ_words >> C_UNIT_SHIFT;
        end else begin
            raw_units = occ_words;
        end
        // Ceiling set at link-up for the active mode
        depth_units = (raw_units > s_reg.max_units) ? s_reg.max_units : raw_units;
    end

    // Live configuration decode, latched only when the link comes up
    always_comb begin
        if (mode_c_i) begin
            // Extended multiblock length in words
            cfg_period = atleast1(LMFC_W'(mblk_e_i) * LMFC_W'(C_WORDS_PER_E));
            // E times 32, saturating where the 512 octets run out
            cfg_max    = umin16(LMFC_W'(mblk_e_i) * LMFC_W'(C_UNITS_PER_E),
                                LMFC_W'(C_SAT_UNITS));
        end else begin
            // K times F octets, four octets per word
            cfg_period = atleast1(LMFC_W'((32'(frames_k_i) * 32'(octets_f_i)) >> 2));
            // K times F over four, bounded by the physical buffer
            cfg_max    = umin16(cfg_period, LMFC_W'(B_SAT_UNITS));
        end
        // Offsets beyond K*S-1 are pulled back to the last legal value
        cfg_ofs_max = LMFC_W'(32'(frames_k_i) * 32'(samples_s_i));
        if (cfg_ofs_max != LMFC_RST) begin
            cfg_ofs_max = cfg_ofs_max - 16'h0001;
        end
    end

    // Next-state logic
    always_comb begin
        s_next = s_reg;

        // Gate enable and edge history
        s_next.sysref_en   = sysref_en_i;
        s_next.sysref_prev = sysref_i;

        // Multiframe counter, restarted by a gated SYSREF edge
        if (sysref_edge) begin
            s_next.lmfc = LMFC_RST;
        end else if (s_reg.lmfc >= s_reg.period - 16'h0001) begin
            s_next.lmfc = LMFC_RST;
        end else begin
            s_next.lmfc = s_reg.lmfc + 16'h0001;
        end

        // Elastic storage write
        if (wr_en) begin
            s_next.mem[s_reg.wr_ptr[IDX_W-1:0]] = fifo_out.data;
            s_next.wr_ptr = s_reg.wr_ptr + 8'h01;
        end

        // Output slot: load on release, clear once taken
        if (rd_en) begin
            s_next.out_valid = 1'b1;
            s_next.out_data  = s_reg.mem[s_reg.rd_ptr[IDX_W-1:0]];
            s_next.rd_ptr    = s_reg.rd_ptr + 8'h01;
        end else if (out_ready_i) begin
            s_next.out_valid = 1'b0;
        end

        // Link alignment sequence
        case (s_reg.st)
            ST_DOWN: begin
                // Pointers held at zero while the link is down
                s_next.wr_ptr    = PTR_RST;
                s_next.rd_ptr    = PTR_RST;
                s_next.out_valid = 1'b0;
                if (link_en_i) begin
                    // Settings only take effect at link-up, so a changed offset
                    // needs the link dropped and restored
                    s_next.mode_c    = mode_c_i;
                    s_next.period    = cfg_period;
                    s_next.rel_pt    = umin16(umin16(offset_i, cfg_ofs_max),
                                              cfg_period - 16'h0001);
                    s_next.max_units = cfg_max[DEPTH_W-1:0];
                    s_next.st        = ST_ALIGN;
                end
            end
            ST_ALIGN: begin
                // Hold reads until the chosen point in the multiframe
                if (!link_en_i) begin
                    s_next.st = ST_DOWN;
                end else if (s_reg.lmfc == s_reg.rel_pt) begin
                    s_next.st = ST_RUN;
                end
            end
            ST_RUN: begin
                // Free-running release; depth stays fixed unless the receiver stalls
                if (!link_en_i) begin
                    s_next.st = ST_DOWN;
                end
            end
            default: begin
                // Illegal code recovers to link down
                s_next.st = ST_DOWN;
            end
        endcase

        // Both depths captured in the same edge so they belong together
        s_next.depth_valid = depth_req_i;
        if (depth_req_i) begin
            s_next.fifo_depth = fifo_cnt;
            s_next.core_depth = depth_units;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '{st:          ST_DOWN,
                       mem:         '0,
                       wr_ptr:      PTR_RST,
                       rd_ptr:      PTR_RST,
                       lmfc:        LMFC_RST,
                       period:      16'h0001,
                       rel_pt:      LMFC_RST,
                       max_units:   DEPTH_RST,
                       mode_c:      1'b0,
                       sysref_en:   1'b0,
                       sysref_prev: 1'b0,
                       out_valid:   1'b0,
                       out_data:    DATA_RST,
                       fifo_depth:  CNT_RST,
                       core_depth:  DEPTH_RST,
                       depth_valid: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

endmodule
`default_nettype wire

// ---- verilog/dfrm_depth_pkg.sv ----
// Shared constants and types for the deframer elastic buffer and its depth monitor
package dfrm_depth_pkg;

    // Data path geometry: one 32-bit word carries four octets
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned WORD_OCTETS  = 4;
    localparam int unsigned EB_OCTETS    = 512;                       // Elastic buffer size
    localparam int unsigned EB_WORDS     = EB_OCTETS / WORD_OCTETS;   // 128 words
    localparam int unsigned IDX_W        = 7;                         // Word index width
    localparam int unsigned PTR_W        = 8;                         // Index plus wrap bit
    localparam int unsigned DEPTH_W      = 8;                         // Reported depth width
    localparam int unsigned LMFC_W       = 16;                        // Multiframe counter width

    // Configuration field widths
    localparam int unsigned K_W          = 9;                         // Frames per multiframe
    localparam int unsigned F_W          = 8;                         // Octets per frame
    localparam int unsigned S_W          = 5;                         // Samples per frame
    localparam int unsigned E_W          = 8;                         // Multiblocks per ext. block
    localparam int unsigned OFS_W        = 16;                        // Offset setting

    // Depth units and limits
    localparam int unsigned B_UNIT_OCTETS  = 4;                       // One step in 204B mode
    localparam int unsigned C_UNIT_OCTETS  = 8;                       // One step in 204C mode
    localparam int unsigned C_UNITS_PER_E  = 32;                      // Steps per multiblock
    localparam int unsigned C_SAT_UNITS    = EB_OCTETS / C_UNIT_OCTETS;              // 64
    localparam int unsigned B_SAT_UNITS    = EB_OCTETS / B_UNIT_OCTETS;              // 128
    localparam int unsigned C_WORDS_PER_E  = C_UNITS_PER_E * C_UNIT_OCTETS / WORD_OCTETS;
    localparam int unsigned C_UNIT_SHIFT   = 1;                       // Words to 8-octet units

    // Reset values and full marks
    localparam logic [PTR_W-1:0]   PTR_RST   = 8'h00;
    localparam logic [PTR_W-1:0]   EB_FULL   = 8'h80;
    localparam logic [LMFC_W-1:0]  LMFC_RST  = 16'h0000;
    localparam logic [DEPTH_W-1:0] DEPTH_RST = 8'h00;
    localparam logic [DATA_W-1:0]  DATA_RST  = 32'h0000_0000;
    localparam logic [1:0]         CNT_RST   = 2'h0;
    localparam logic [1:0]         CNT_FULL  = 2'h2;

    // Link alignment states, one-hot
    typedef enum logic [2:0] {
        ST_DOWN  = 3'b001,
        ST_ALIGN = 3'b010,
        ST_RUN   = 3'b100
    } link_state_t;

    // Smaller of two 16-bit values
    function automatic logic [LMFC_W-1:0] umin16(input logic [LMFC_W-1:0] a,
                                                 input logic [LMFC_W-1:0] b);
        umin16 = (a < b) ? a : b;
    endfunction

    // Never below one, so a zero field cannot stall the counter
    function automatic logic [LMFC_W-1:0] atleast1(input logic [LMFC_W-1:0] a);
        atleast1 = (a == LMFC_RST) ? 16'h0001 : a;
    endfunction

endpackage

// ---- verilog/word_stream_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Valid/ready word stream between the buffer and the deframer core
interface word_stream_if;
    import dfrm_depth_pkg::*;
    logic              valid;   // Word offered
    logic              ready;   // Word accepted when both high
    logic [DATA_W-1:0] data;    // Four octets
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- verilog/two_entry_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-entry input FIFO; ready comes from a flop so the link sees a clean signal
module two_entry_buffer (
    input  wire logic          ref_clk_i,
    input  wire logic          rst_n_i,
    word_stream_if.snk         in_s,
    word_stream_if.src         out_s,
    output logic [1:0]         count_o
);
    import dfrm_depth_pkg::*;

    typedef struct packed {
        logic [1:0][DATA_W-1:0] mem;    // Entry 0 is the head
        logic [1:0]             cnt;    // Occupancy 0..2
        logic                   rdy;    // Room for one more
    } buf_state_t;

    buf_state_t s_reg;
    buf_state_t s_next;
    logic       push;
    logic       pop;

    assign in_s.ready  = s_reg.rdy;
    assign out_s.valid = (s_reg.cnt != CNT_RST);
    assign out_s.data  = s_reg.mem[0];
    assign count_o     = s_reg.cnt;
    assign push        = in_s.valid & s_reg.rdy;
    assign pop         = out_s.valid & out_s.ready;

    // Shift on pop, write behind the remaining entries on push
    always_comb begin
        s_next = s_reg;
        if (pop) begin
            s_next.mem[0] = s_reg.mem[1];
        end
        if (push) begin
            if (s_reg.cnt == CNT_RST || (s_reg.cnt == 2'h1 && pop)) begin
                s_next.mem[0] = in_s.data;
            end else begin
                s_next.mem[1] = in_s.data;
            end
        end
        s_next.cnt = s_reg.cnt + {1'b0, push} - {1'b0, pop};
        s_next.rdy = (s_next.cnt != CNT_FULL);
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '{mem: '0, cnt: CNT_RST, rdy: 1'b1};
        end else begin
            s_reg <= s_next;
        end
    end

endmodule
`default_nettype wire

// ---- testbench/dfrm_depth_monitor_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the depth monitor
module dfrm_depth_monitor_asserts (
    input wire logic                              ref_clk_i,
    input wire logic                              rst_n_i,
    input wire logic                              link_en_i,
    input wire logic                              mode_c_i,
    input wire logic [dfrm_depth_pkg::K_W-1:0]    frames_k_i,
    input wire logic [dfrm_depth_pkg::F_W-1:0]    octets_f_i,
    input wire logic [dfrm_depth_pkg::E_W-1:0]    mblk_e_i,
    input wire logic                              sysref_en_i,
    input wire logic                              sysref_en_o,
    input wire logic                              depth_req_i,
    input wire logic [1:0]                        fifo_depth_o,
    input wire logic [dfrm_depth_pkg::DEPTH_W-1:0] core_depth_o,
    input wire logic                              depth_valid_o,
    input wire logic                              aligned_o,
    input wire logic                              out_valid_o,
    input wire logic [dfrm_depth_pkg::DATA_W-1:0] out_data_o,
    input wire logic                              out_ready_i,
    input wire logic                              link_ready_o
);
    import dfrm_depth_pkg::*;
    logic [16:0] kf_cap;    // K times F, before the divide by four
    logic [12:0] e_cap;     // E times 32
    // Ceilings follow live config; bench only changes it with the link down
    assign kf_cap = 17'(frames_k_i) * 17'(octets_f_i);
    assign e_cap  = {mblk_e_i, 5'h00};
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    depth_answer_a: assert property (
        depth_req_i ##1 !depth_req_i |-> depth_valid_o ##1 !depth_valid_o)
        else $error("depth answer not one cycle after request");
    depth_hold_a: assert property (
        !depth_valid_o |-> $stable(core_depth_o) && $stable(fifo_depth_o))
        else $error("depth changed without a snapshot");
    fifo_range_a: assert property (
        depth_valid_o |-> fifo_depth_o <= 2'h2)
        else $error("input fifo depth above two");
    b_cap_a: assert property (
        depth_valid_o && !mode_c_i |-> 17'(core_depth_o) <= (kf_cap >> 2) || core_depth_o <= 8'h01)
        else $error("depth above K*F/4 in B mode");
    c_cap_a: assert property (
        depth_valid_o && mode_c_i |-> 13'(core_depth_o) <= e_cap && core_depth_o <= 8'h40)
        else $error("depth above E*32 or 64 in C mode");
    gate_readback_a: assert property (
        $changed(sysref_en_i) |=> sysref_en_o == $past(sysref_en_i))
        else $error("gate readback does not follow enable");
    down_empty_a: assert property (
        !link_en_i [*3] ##1 (depth_req_i && !link_en_i) |=> core_depth_o == 8'h00)
        else $error("depth not zero with pointers cleared");
    align_bound_a: assert property (
        $rose(link_en_i) && e_cap < 13'h00C1 && kf_cap < 17'h0601 |-> ##[1:400] aligned_o)
        else $error("link never released the buffer");
    out_stall_a: assert property (
        out_valid_o && !out_ready_i && link_en_i |=> out_valid_o && $stable(out_data_o))
        else $error("stalled output word lost");

    // Main scenarios reached
    cover property (!link_ready_o);
    cover property (depth_valid_o && mode_c_i && core_depth_o == 8'h40);
    cover property (out_valid_o && !out_ready_i);
endmodule
bind dfrm_depth_monitor dfrm_depth_monitor_asserts chk (.ref_clk_i, .rst_n_i, .link_en_i,
    .mode_c_i, .frames_k_i, .octets_f_i, .mblk_e_i, .sysref_en_i, .sysref_en_o, .depth_req_i,
    .fifo_depth_o, .core_depth_o, .depth_valid_o, .aligned_o, .out_valid_o, .out_data_o,
    .out_ready_i, .link_ready_o);
`default_nettype wire

// ---- testbench/framer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far-end framer: offers a numbered word burst, holds each until taken
module framer_model (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        go_i,      // Start a burst
    input  wire logic [7:0]  burst_i,   // Words in the burst
    input  wire logic        ready_i,   // Device has room
    output logic             valid_o,
    output logic [31:0]      data_o,
    output logic             busy_o
);
    logic [7:0]  left_reg;  // Words still to offer
    logic [31:0] seq_reg;   // Next word number
    assign busy_o = valid_o || (left_reg != 8'h00);
    // Idle data is inverted so a stale word never looks valid
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_reg <= 8'h00;
            seq_reg  <= 32'h0000_0000;
            valid_o  <= 1'b0;
            data_o   <= 32'hFFFF_FFFF;
        end else begin
            if (valid_o && ready_i) begin
                valid_o <= 1'b0;
                data_o  <= ~data_o;
                seq_reg <= seq_reg + 32'h0000_0001;
            end
            if (go_i) begin
                left_reg <= burst_i;
            end else if ((!valid_o || ready_i) && left_reg != 8'h00) begin
                valid_o  <= 1'b1;
                data_o   <= 32'hA5A5_0000 + seq_reg + 32'(valid_o && ready_i);
                left_reg <= left_reg - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_dfrm_depth_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// Depth monitor bench: fill, snapshot, drain in both link modes
module tb_dfrm_depth_monitor;
    import dfrm_depth_pkg::*;
    logic        ref_clk_i, rst_n_i, link_valid_i, link_ready_o, link_en_i, mode_c_i;
    logic        sysref_i, sysref_en_i, sysref_en_o, depth_req_i, depth_valid_o;
    logic        aligned_o, out_valid_o, out_ready_i, go, busy;
    logic [31:0] link_data_i, out_data_o, exp_seq;
    logic [8:0]  frames_k_i;
    logic [7:0]  octets_f_i, mblk_e_i, burst, core_depth_o, d0, d1;
    logic [4:0]  samples_s_i;
    logic [15:0] offset_i;
    logic [1:0]  fifo_depth_o;
    int          n_mismatch, compares;

    dfrm_depth_monitor uut (.ref_clk_i, .rst_n_i, .link_valid_i, .link_data_i, .link_ready_o,
        .link_en_i, .mode_c_i, .frames_k_i, .octets_f_i, .samples_s_i, .mblk_e_i, .offset_i,
        .sysref_i, .sysref_en_i, .sysref_en_o, .depth_req_i, .fifo_depth_o, .core_depth_o,
        .depth_valid_o, .aligned_o, .out_valid_o, .out_data_o, .out_ready_i);
    framer_model fm (.ref_clk_i, .rst_n_i, .go_i(go), .burst_i(burst), .ready_i(link_ready_o),
        .valid_o(link_valid_i), .data_o(link_data_i), .busy_o(busy));

    // 200 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // Start a burst from the framer; does not wait
    task automatic send(input logic [7:0] n);
        @(posedge ref_clk_i) go <= 1'b1;
        burst <= n;
        @(posedge ref_clk_i) go <= 1'b0;
    endtask
    // Wait for the framer to finish, then let the pipeline settle
    task automatic idle;
        cyc(1);
        for (int i = 0; i < 400 && busy === 1'b1; i++) @(posedge ref_clk_i);
        cyc(4);
    endtask
    task automatic snap(output logic [7:0] d);
        @(posedge ref_clk_i) depth_req_i <= 1'b1;
        @(posedge ref_clk_i) depth_req_i <= 1'b0;
        #1 check(depth_valid_o, 1'b1);
        d = core_depth_o;
    endtask
    // Offset kept inside K*S-1 so the depth keeps margin
    task automatic link_up(input logic c, input logic [8:0] k, input logic [7:0] f, e);
        @(posedge ref_clk_i) mode_c_i <= c;
        frames_k_i <= k;
        octets_f_i <= f;
        mblk_e_i <= e;
        offset_i <= 16'h0002;
        link_en_i <= 1'b1;
        sysref_i <= 1'b0;
        for (int i = 0; i < 600 && aligned_o !== 1'b1; i++) @(posedge ref_clk_i);
        check(aligned_o, 1'b1);
    endtask
    task automatic link_down;
        @(posedge ref_clk_i) link_en_i <= 1'b0;
        sysref_i <= 1'b1;
        cyc(3);
    endtask
    // Receiver takes n words, each checked in order
    task automatic drain(input int n);
        int got;
        got = 0;
        @(posedge ref_clk_i) out_ready_i <= 1'b1;
        for (int i = 0; i < 2000 && got < n; i++) begin
            @(posedge ref_clk_i);
            if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
                check(out_data_o, 32'hA5A5_0000 + exp_seq);
                exp_seq++;
                got++;
            end
        end
        out_ready_i <= 1'b0;
        check(got, n);
    endtask

    // Depth step of one unit per four octets; offset cancels
    task automatic t_bstep;
        link_up(1'b0, 9'h020, 8'h04, 8'h00);
        send(8'h06);
        idle;
        snap(d0);
        send(8'h04);
        idle;
        snap(d1);
        check(8'(d1 - d0), 8'h04);
        drain(10);
    endtask
    task automatic t_gate;
        @(posedge ref_clk_i) sysref_en_i <= 1'b1;
        @(posedge ref_clk_i) sysref_i <= 1'b1;
        #1 check(sysref_en_o, 1'b1);
        @(posedge ref_clk_i) sysref_i <= 1'b0;
        sysref_en_i <= 1'b0;
        @(posedge ref_clk_i);
        #1 check(sysref_en_o, 1'b0);
    endtask
    // Small multiframe clamps the B depth at K*F/4
    task automatic t_bcap;
        link_down;
        link_up(1'b0, 9'h004, 8'h04, 8'h00);
        send(8'h14);
        idle;
        snap(d0);
        check(d0, 8'h04);
        drain(20);
    endtask
    task automatic t_cmode;
        link_down;
        link_up(1'b1, 9'h020, 8'h04, 8'h01);
        send(8'h06);
        idle;
        snap(d0);
        send(8'h04);
        idle;
        snap(d1);
        check(8'(d1 - d0), 8'h02);
        send(8'h50);
        idle;
        snap(d0);
        check(d0, 8'h20);
        drain(90);
    endtask
    // Stalled receiver: fill until refused, then drain it all
    task automatic t_full;
        link_down;
        link_up(1'b1, 9'h020, 8'h04, 8'h03);
        send(8'h8C);
        cyc(300);
        snap(d0);
        check(d0, 8'h40);
        check(fifo_depth_o, 2'h2);
        check(link_ready_o, 1'b0);
        drain(140);
    endtask
    task automatic t_down;
        link_down;
        snap(d0);
        check(d0, 8'h00);
        check(aligned_o, 1'b0);
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #100000;
        n_mismatch++;
        close_out;
    end
    initial begin
        n_mismatch = 0;
        compares = 0;
        exp_seq = 32'h0000_0000;
        rst_n_i = 1'b0;
        {link_en_i, mode_c_i, sysref_i, sysref_en_i, depth_req_i, out_ready_i, go} = 7'h00;
        frames_k_i = 9'h020;
        octets_f_i = 8'h04;
        samples_s_i = 5'h01;
        mblk_e_i = 8'h01;
        offset_i = 16'h0000;
        burst = 8'h00;
        cyc(4);
        rst_n_i <= 1'b1;
        cyc(1);
        #1 check({link_ready_o, aligned_o, out_valid_o, depth_valid_o, sysref_en_o}, 5'h10);
        t_bstep;
        t_gate;
        t_bcap;
        t_cmode;
        t_full;
        t_down;
        close_out;
    end
endmodule
`default_nettype wire
